// ### shared/spcs_map.vh
// register offsets, field positions, reset values and rate codes of the serial control block
`ifndef SPCS_MAP_VH
`define SPCS_MAP_VH
`define SPCS_CONTROL_OFFSET  8'hc3
`define SPCS_STATUS_OFFSET   8'hc4
`define SPCS_DATA_OFFSET     8'hc5
`define SPCS_CONTROL_RESET   8'h14
`define SPCS_BIT_RATE_HIGH   7
`define SPCS_BIT_ENABLE      6
`define SPCS_BIT_SEL_DISABLE 5
`define SPCS_BIT_MASTER      4
`define SPCS_BIT_IDLE_LEVEL  3
`define SPCS_BIT_SAMPLE_EDGE 2
`define SPCS_BIT_RATE_MID    1
`define SPCS_BIT_RATE_LOW    0
`define SPCS_BIT_DONE        7
`define SPCS_BIT_COLLISION   6
`define SPCS_BIT_SEL_ERROR   5
`define SPCS_BIT_MODE_FAULT  4
`define SPCS_RATE_DIV4       3'h1
`define SPCS_RATE_DIV128     3'h6
`endif

// ### rtl/spcs_shifter.v
// byte shift engine: one byte per transfer, both roles, all four clock modes
`timescale 1ns/1ps
`default_nettype none
module spcs_shifter #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             reset,
  // control
  input  wire             enable,
  input  wire             master,
  input  wire             idleLevel,
  input  wire             sampleEdge,
  input  wire [2:0]       rateCode,
  input  wire             load,
  input  wire [WIDTH-1:0] loadData,
  // synchronised slave side pins
  input  wire             slaveClk,
  input  wire             slaveSelected,
  input  wire             dataIn,
  // results
  output reg              busy,
  output reg              done,
  output reg  [WIDTH-1:0] rxData,
  output reg              sclkOut,
  output wire             dataOut
);
  reg [WIDTH-1:0] shift_r;
  reg [3:0]       edges_r;
  reg [6:0]       divCnt_r;
  reg             prevClk_r;
  reg             inBit_r;
  reg             lateSample_r;
  reg             lastPend_r;
  wire [6:0]      halfDiv;
  wire            masterTick;
  wire            slaveEdge;
  wire            sampleNow;

  // half period of ref_clk / (2^(code+1)) : code 1 -> div 4
  assign halfDiv    = (7'h01 << rateCode) - 7'h01;
  assign masterTick = master & busy & (divCnt_r == halfDiv);
  assign slaveEdge  = ~master & slaveSelected & (slaveClk != prevClk_r);
  // leading edge leaves idle; odd edge count after first is the trailing one
  assign sampleNow  = (masterTick | slaveEdge) & (edges_r[0] == sampleEdge);
  assign dataOut    = shift_r[WIDTH-1];

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shift_r   <= {WIDTH{1'b0}};
      edges_r   <= 4'h0;
      divCnt_r  <= 7'h00;
      prevClk_r <= 1'b0;
      inBit_r   <= 1'b0;
      lateSample_r <= 1'b0;
      lastPend_r   <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
      rxData    <= {WIDTH{1'b0}};
      sclkOut   <= 1'b0;
    end else begin
      done      <= 1'b0;
      prevClk_r <= slaveClk;
      lateSample_r <= masterTick & sampleNow;
      if (!enable) begin
        busy     <= 1'b0;
        lastPend_r <= 1'b0;
        edges_r  <= 4'h0;
        divCnt_r <= 7'h00;
        sclkOut  <= idleLevel;
      end else begin
        if (!busy) begin
          sclkOut <= idleLevel;
          edges_r <= 4'h0;
          if (load) begin
            shift_r <= loadData;
            busy    <= master | slaveSelected;
          end else if (!master && slaveSelected && slaveClk != idleLevel) begin
            busy <= 1'b1;
          end
        end
        if (busy || slaveEdge) begin
          divCnt_r <= masterTick ? 7'h00 : divCnt_r + 7'h01;
          if (masterTick | slaveEdge) begin
            if (master)
              sclkOut <= ~sclkOut;
            if (sampleNow && !master)
              inBit_r <= dataIn;
            else if (!sampleNow && (edges_r != 4'h0 || !sampleEdge))
              shift_r <= {shift_r[WIDTH-2:0], inBit_r};
            edges_r <= edges_r + 4'h1;
            if (edges_r == 4'hf && master) begin
              lastPend_r <= 1'b1;
            end else if (edges_r == 4'hf) begin
              busy   <= 1'b0;
              done   <= 1'b1;
              rxData <= sampleEdge ? {shift_r[WIDTH-2:0], dataIn}
                                   : {shift_r[WIDTH-2:0], inBit_r};
            end
          end
        end
        // master data returns through the two sync stages, so it is taken one cycle late;
        // this is why the fastest rate needs a half period of at least two cycles
        if (lateSample_r)
          inBit_r <= dataIn;
        if (lastPend_r) begin
          lastPend_r <= 1'b0;
          busy       <= 1'b0;
          done       <= 1'b1;
          rxData     <= sampleEdge ? {shift_r[WIDTH-2:0], dataIn} : shift_r;
        end
      end
    end
  end
endmodule // spcs_shifter
`default_nettype wire

// ### rtl/spcs_control_status.v
// control, status and select-pin supervision of the serial peripheral port
// Operation
// - mode fault with select pin enabled raises the receiver/error interrupt
// - select pin level contradicting the role sets mode fault
// - clearing enable disables the port and resets the serial state machine
// - select disable ignores the select pin; slave ignores it only when phase is one
// - control bit 4 set means master, cleared means slave
// - control bit 3 gives the idle level of the serial clock
// - control bit 2 chooses sampling on leaving or returning to idle
// - rate codes 1 to 6 divide the source clock by 4 up to 128
// - transfer done flag in status bit 7 sets when a byte finishes
// - done flag reads zero during transfer and clears after its sequence
// - collision flag in status bit 6 sets on data write during transfer
// - collision flag is zero without collision and clears after its sequence
// - select error flag in status bit 5 sets on select change mid byte
// - select error flag clears only by clearing the enable bit
// - mode fault flag in status bit 4 clears after its sequence
// - control register resets to 14h: master, phase one, disabled, rate 0
// - mode fault clears the enable and master bits
// - status read with fault set then control write clears mode fault
// - done flag drives the transmitter interrupt request
// - status read then data access clears collision; transfer continues
`include "spcs_map.vh"
`timescale 1ns/1ps
`default_nettype none
module spcs_control_status #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             reset,
  // register port
  input  wire [7:0]       regAddr,
  input  wire [7:0]       regWrData,
  input  wire             regWrite,
  input  wire             regRead,
  output reg  [7:0]       regRdData,
  // serial pins
  input  wire             selectPinIn,
  input  wire             serialClockPinIn,
  input  wire             dataPinIn,
  output wire             serialClockPinOut,
  output wire             serialClockPinOe_n,
  output wire             dataPinOut,
  output wire             dataPinOe_n,
  // interrupt requests
  output wire             txIrq,
  output wire             rxErrIrq
);
  reg  [7:0]       control_r;
  reg              doneFlag_r;
  reg              collisionFlag_r;
  reg              selErrFlag_r;
  reg              faultFlag_r;
  reg              doneArmed_r;
  reg              collArmed_r;
  reg              faultArmed_r;
  reg  [3:0]       reservedBits_r;
  reg  [2:0]       selSync_r;
  reg  [1:0]       clkSync_r;
  reg  [1:0]       dataSync_r;
  wire             selLevel;
  wire             enable;
  wire             master;
  wire             selDisable;
  wire             sampleEdge;
  wire             selIgnored;
  wire             slaveSelected;
  wire             faultEvent;
  wire             selErrEvent;
  wire             ctrlWrite;
  wire             statusRead;
  wire             dataAccess;
  wire             dataWrite;
  wire             busy;
  wire             done;
  wire [WIDTH-1:0] rxData;
  wire             sclkOut;
  wire             shiftOut;

  assign enable     = control_r[`SPCS_BIT_ENABLE];
  assign master     = control_r[`SPCS_BIT_MASTER];
  assign selDisable = control_r[`SPCS_BIT_SEL_DISABLE];
  assign sampleEdge = control_r[`SPCS_BIT_SAMPLE_EDGE];
  assign selLevel   = selSync_r[1];

  // slave with phase zero needs the select edge to frame bytes, so it is never ignored
  assign selIgnored    = selDisable & (master | sampleEdge);
  assign slaveSelected = selIgnored | ~selLevel;
  // a low select while master means another master drives the bus
  assign faultEvent    = enable & master & ~selIgnored & ~selLevel;
  // select rising while a slave byte is still open
  assign selErrEvent   = enable & ~master & ~selIgnored & busy
                         & selLevel & ~selSync_r[2];

  assign ctrlWrite  = regWrite & (regAddr == `SPCS_CONTROL_OFFSET);
  assign statusRead = regRead & (regAddr == `SPCS_STATUS_OFFSET);
  assign dataWrite  = regWrite & (regAddr == `SPCS_DATA_OFFSET);
  assign dataAccess = dataWrite | (regRead & (regAddr == `SPCS_DATA_OFFSET));

  // outputs: drive only while enabled and the owning role
  assign serialClockPinOut  = sclkOut;
  assign serialClockPinOe_n = ~(enable & master);
  assign dataPinOut         = shiftOut;
  assign dataPinOe_n        = ~(enable & (master | (slaveSelected & ~selIgnored)));

  assign txIrq    = doneFlag_r;
  assign rxErrIrq = faultFlag_r & ~selDisable;

  // pins cross into ref_clk through two flops; the third stage feeds the edge detect
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      selSync_r  <= 3'h7;
      clkSync_r  <= 2'h0;
      dataSync_r <= 2'h0;
    end else begin
      selSync_r  <= {selSync_r[1:0], selectPinIn};
      clkSync_r  <= {clkSync_r[0], serialClockPinIn};
      dataSync_r <= {dataSync_r[0], dataPinIn};
    end
  end

  // control register
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      control_r <= `SPCS_CONTROL_RESET;
    end else begin
      if (ctrlWrite)
        control_r <= regWrData;
      if (faultEvent) begin
        control_r[`SPCS_BIT_ENABLE] <= 1'b0;
        control_r[`SPCS_BIT_MASTER] <= 1'b0;
      end
    end
  end

  // status flags: a set in the same cycle as its clear wins
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      doneFlag_r      <= 1'b0;
      collisionFlag_r <= 1'b0;
      selErrFlag_r    <= 1'b0;
      faultFlag_r     <= 1'b0;
      doneArmed_r     <= 1'b0;
      collArmed_r     <= 1'b0;
      faultArmed_r    <= 1'b0;
      reservedBits_r  <= 4'h0;
    end else begin
      if (statusRead) begin
        doneArmed_r  <= doneFlag_r;
        collArmed_r  <= 1'b1;
        faultArmed_r <= faultFlag_r;
      end
      if (busy)
        doneFlag_r <= 1'b0;
      else if (done)
        doneFlag_r <= 1'b1;
      else if (dataAccess && doneArmed_r && !statusRead) begin
        doneFlag_r  <= 1'b0;
        doneArmed_r <= 1'b0;
      end
      if (dataWrite && busy)
        collisionFlag_r <= 1'b1;
      else if (dataAccess && collArmed_r && !statusRead) begin
        collisionFlag_r <= 1'b0;
        collArmed_r     <= 1'b0;
      end
      if (selErrEvent)
        selErrFlag_r <= 1'b1;
      else if (!enable)
        selErrFlag_r <= 1'b0;
      if (faultEvent)
        faultFlag_r <= 1'b1;
      else if (ctrlWrite && faultArmed_r) begin
        faultFlag_r  <= 1'b0;
        faultArmed_r <= 1'b0;
      end
      // reserved bits keep what software writes so that a read-modify-write returns them
      if (regWrite && regAddr == `SPCS_STATUS_OFFSET)
        reservedBits_r <= regWrData[3:0];
    end
  end

  // read data one cycle after the strobe; unmapped addresses read zero
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `SPCS_CONTROL_OFFSET: regRdData <= control_r;
        `SPCS_STATUS_OFFSET:  regRdData <= {doneFlag_r, collisionFlag_r, selErrFlag_r,
                                            faultFlag_r, reservedBits_r};
        `SPCS_DATA_OFFSET:    regRdData <= rxData;
        default:              regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // a write while busy is dropped by the engine, so the transfer continues
  spcs_shifter #(
    .WIDTH(WIDTH)
  ) u_shifter (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .enable       (enable),
    .master       (master),
    .idleLevel    (control_r[`SPCS_BIT_IDLE_LEVEL]),
    .sampleEdge   (sampleEdge),
    .rateCode     ({control_r[`SPCS_BIT_RATE_HIGH], control_r[`SPCS_BIT_RATE_MID],
                    control_r[`SPCS_BIT_RATE_LOW]}),
    .load         (dataWrite & ~busy),
    .loadData     (regWrData),
    .slaveClk     (clkSync_r[1]),
    .slaveSelected(slaveSelected),
    .dataIn       (dataSync_r[1]),
    .busy         (busy),
    .done         (done),
    .rxData       (rxData),
    .sclkOut      (sclkOut),
    .dataOut      (shiftOut)
  );
endmodule // spcs_control_status
`default_nettype wire

// ### testbench/spcs_control_status_sva.sv
// assertion checker for registers, pins and requests of the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "spcs_map.vh"
module spcs_control_status_sva (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  // pins and requests
  input wire logic       selectPinIn,
  input wire logic       serialClockPinOe_n,
  input wire logic       txIrq,
  input wire logic       rxErrIrq
);
  localparam logic [7:0] CTL = `SPCS_CONTROL_OFFSET;
  localparam logic [7:0] STA = `SPCS_STATUS_OFFSET;
  localparam logic [7:0] DAT = `SPCS_DATA_OFFSET;
  logic [7:0] ctlR;
  // shadow of software writes; hardware may only clear bits 6 and 4 behind it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) ctlR <= `SPCS_CONTROL_RESET;
    else if (regWrite && regAddr == CTL) ctlR <= regWrData;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_stRd; regRead && regAddr == STA; endsequence
  sequence s_datAcc; (regRead || regWrite) && regAddr == DAT; endsequence
  property p_faultSet;
    (!serialClockPinOe_n && !selectPinIn && !ctlR[5]) [*3] |-> ##[0:3] rxErrIrq;
  endproperty
  property p_faultOff; $rose(rxErrIrq) |-> ##[0:1] serialClockPinOe_n; endproperty
  property p_oeMaster; !serialClockPinOe_n |-> ctlR[6] && ctlR[4]; endproperty
  property p_ctlRead;
    regRead && regAddr == CTL |=> (regRdData & 8'haf) == ($past(ctlR) & 8'haf);
  endproperty
  property p_doneRead; s_stRd |=> regRdData[7] == $past(txIrq); endproperty
  property p_faultRead;
    s_stRd ##0 !ctlR[5] |=> regRdData[4] == $past(rxErrIrq);
  endproperty
  property p_doneClr; s_stRd ##0 txIrq ##[1:4] s_datAcc |-> ##[1:2] !txIrq; endproperty
  property p_faultClr;
    s_stRd ##0 rxErrIrq ##[1:8] (regWrite && regAddr == CTL) |-> ##1 !rxErrIrq;
  endproperty
  a_faultSet: assert property (p_faultSet) else $error("mode fault missed");
  a_faultOff: assert property (p_faultOff) else $error("port kept driving");
  a_oeMaster: assert property (p_oeMaster) else $error("clock driven as slave");
  a_ctlRead: assert property (p_ctlRead) else $error("control readback");
  a_doneRead: assert property (p_doneRead) else $error("done bit readback");
  a_faultRead: assert property (p_faultRead) else $error("fault bit readback");
  a_doneClr: assert property (p_doneClr) else $error("done not cleared");
  a_faultClr: assert property (p_faultClr) else $error("fault not cleared");
endmodule // spcs_control_status_sva
bind spcs_control_status spcs_control_status_sva u_sva (.ref_clk, .reset, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .selectPinIn, .serialClockPinOe_n,
  .txIrq, .rxErrIrq);
`default_nettype wire

// ### testbench/spcs_slave_model.sv
// far-side serial slave: clock modes 0 and 1, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module spcs_slave_model (
  // serial wires
  input  wire logic       sclk,
  input  wire logic       selN,
  input  wire logic       mosi,
  output var  logic       miso,
  // clock phase, byte to send and byte seen
  input  wire logic       sampling_edge_select,
  input  wire logic [7:0] txByte,
  output var  logic [7:0] rxByte
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  initial rxByte = 8'h00;
  always @(negedge selN) begin
    sh = txByte;
    miso = txByte[7];
  end
  // phase one launches on the leading edge, so its first launch repeats bit 7
  always @(posedge sclk) begin
    if (!selN && sampling_edge_select) begin
      miso = sh[7];
      sh = {sh[6:0], 1'b0};
    end else if (!selN) begin
      rxByte = {rxByte[6:0], mosi};
    end
  end
  always @(negedge sclk) begin
    if (!selN && sampling_edge_select) begin
      rxByte = {rxByte[6:0], mosi};
    end else if (!selN) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end
  // released line flips so a stale bit is never mistaken for data
  always @(posedge selN) miso = ~miso;
endmodule // spcs_slave_model
`default_nettype wire

// ### testbench/spcs_control_status_tb.sv
// self-checking bench for the serial control block
`timescale 1ns/1ps
`default_nettype none
`include "spcs_map.vh"
module spcs_control_status_tb;
  localparam logic [7:0] CTL = `SPCS_CONTROL_OFFSET;
  localparam logic [7:0] STA = `SPCS_STATUS_OFFSET;
  localparam logic [7:0] DAT = `SPCS_DATA_OFFSET;
  logic ref_clk = 0, reset = 1, regWrite = 0, regRead = 0;
  logic selectPinIn = 1, tbClk = 0, slvSelN = 1, slvCpha = 0;
  logic [7:0] regAddr = 0, regWrData = 0, txByte = 0;
  wire [7:0] regRdData, rxByte;
  wire sclkOut, sclkOe_n, mosi, mosiOe_n, miso, txIrq, rxErrIrq;
  wire sclkWire = sclkOe_n ? tbClk : sclkOut;
  int errors = 0, n_checks = 0, n, t;
  always #2.5 ref_clk = ~ref_clk;
  spcs_control_status dut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .selectPinIn(selectPinIn), .serialClockPinIn(sclkWire), .dataPinIn(miso),
    .serialClockPinOut(sclkOut), .serialClockPinOe_n(sclkOe_n), .dataPinOut(mosi),
    .dataPinOe_n(mosiOe_n), .txIrq(txIrq), .rxErrIrq(rxErrIrq));
  spcs_slave_model peer (.sclk(sclkWire), .selN(slvSelN), .mosi(mosi), .miso(miso),
    .sampling_edge_select(slvCpha), .txByte(txByte), .rxByte(rxByte));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, m, e);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regRdData & m, e);
    @(posedge ref_clk);
  endtask
  // bounded wait on one request line; a timeout ends the run
  task automatic waitFor(input logic rx, input int lim);
    n = 0;
    while ((rx ? rxErrIrq : txIrq) !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      $display("unexpected at %0t: wait %h of %h", $time, n, lim);
      stop_test();
    end
  endtask
  // status is only read, never written, and its low nibble is masked off
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(CTL, 8'hff, `SPCS_CONTROL_RESET);
    rd(STA, 8'hf0, 8'h00);
    rd(8'hc7, 8'hff, 8'h00);
    $display("test reset done");
    for (int c = 1; c <= 6; c++) begin
      txByte <= 8'h3c ^ c[7:0];
      slvCpha <= (c == 3);
      wr(CTL, {c[2], 4'ha, c == 3, c[1:0]});
      slvSelN <= 1'b0;
      wr(DAT, 8'ha5 ^ c[7:0]);
      if (c == 1) begin
        wr(DAT, 8'h0f);
        rd(STA, 8'hf0, 8'h40);
      end
      waitFor(0, 3000);
      t = n + (c == 1 ? 4 : 0);
      chk({7'h0, t >= (16 << c) - 4 && t <= (16 << c) + 8}, 8'h01);
      chk({7'h0, mosiOe_n}, 8'h00);
      rd(STA, 8'hf0, c == 1 ? 8'hc0 : 8'h80);
      rd(DAT, 8'hff, 8'h3c ^ c[7:0]);
      slvSelN <= 1'b1;
      rd(STA, 8'hf0, 8'h00);
      chk(rxByte, 8'ha5 ^ c[7:0]);
      chk({7'h0, sclkWire}, 8'h00);
    end
    wr(CTL, 8'h59);
    repeat (4) @(posedge ref_clk);
    chk({7'h0, sclkWire}, 8'h01);
    $display("test transfers done");
    wr(CTL, 8'h50);
    selectPinIn <= 1'b0;
    waitFor(1, 20);
    rd(CTL, 8'hff, 8'h00);
    rd(STA, 8'hf0, 8'h10);
    selectPinIn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wr(CTL, 8'h50);
    rd(STA, 8'hf0, 8'h00);
    wr(CTL, 8'h70);
    selectPinIn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({7'h0, rxErrIrq}, 8'h00);
    rd(STA, 8'hf0, 8'h00);
    selectPinIn <= 1'b1;
    $display("test mode fault done");
    wr(CTL, 8'h44);
    selectPinIn <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      repeat (8) @(posedge ref_clk);
      tbClk <= ~tbClk;
    end
    selectPinIn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(STA, 8'hf0, 8'h20);
    wr(CTL, 8'h44);
    rd(STA, 8'hf0, 8'h20);
    wr(CTL, 8'h04);
    rd(STA, 8'hf0, 8'h00);
    chk({7'h0, mosiOe_n}, 8'h01);
    $display("test select error done");
    stop_test();
  end
endmodule // spcs_control_status_tb
`default_nettype wire
